//--- pkg/tx_ctrl_pkg.sv
// constants for the serially loaded transmitter control registers
package tx_ctrl_pkg;
	localparam int FRAME_BITS = 24;
	localparam int ADDR_BITS = 4;
	localparam logic [3:0] ADDR_OPERATING_CONTROL_WORD = 4'h4;
	localparam logic [3:0] ADDR_SETUP = 4'h5;
	localparam logic [3:0] ADDR_TEST = 4'h7;
	localparam logic [15:0] OPERATING_CONTROL_WORD_RESET = 16'h892f;
	localparam logic [15:0] SETUP_RESET = 16'hd03f;
	localparam logic [7:0] TEST_RESET = 8'h00;
	// operating control word fields
	localparam int OP_LO_PORT_SELECT = 15;
	localparam int OP_RF_HOLD = 14;
	localparam int OP_IF_HOLD = 13;
	localparam int OP_MODE_HI = 12;
	localparam int OP_MODE_LO = 11;
	localparam int OP_IF_BAND = 10;
	localparam int OP_OSC_HI = 9;
	localparam int OP_GAIN_HI = 8;
	localparam int OP_GAIN_LO = 6;
	localparam int OP_SIDEBAND = 5;
	localparam int OP_TAP_ON = 4;
	localparam int OP_MODKIND = 3;
	localparam int OP_STANDBY_KEEP_REGS = 2;
	localparam int OP_TXHOLD = 1;
	localparam int OP_SOFTOFF = 0;
	// setup word fields
	localparam int CF_IF_SYNTH = 15;
	localparam int CF_RF_SYNTH = 14;
	localparam int CF_LEVEL = 12;
	localparam int CF_HALVE = 11;
	localparam int CF_EXTOSC = 10;
	localparam int CF_ICP_HI = 9;
	localparam int CF_ICP_LO = 8;
	localparam int CF_RCP_HI = 7;
	localparam int CF_RCP_LO = 6;
	localparam int CF_IF_POL = 5;
	localparam int CF_RF_POL = 4;
	localparam int CF_IF_FAST = 3;
	localparam int CF_RF_FAST = 2;
	localparam int CF_SETTLE_HI = 1;
	localparam int CF_SETTLE_LO = 0;
	localparam logic [1:0] BAND_FM = 2'b00;
	localparam logic [1:0] BAND_CELL = 2'b01;
	localparam logic [1:0] BAND_PCS_HI = 2'b10;
	localparam logic [1:0] BAND_PCS_LO = 2'b11;
	localparam logic [1:0] SETTLE_IF = 2'b01;
	localparam logic [1:0] SETTLE_RF = 2'b10;
	localparam logic [1:0] SETTLE_BOTH = 2'b11;
	localparam logic [1:0] REVERSALS_END = 2'd2;
	typedef enum logic [1:0] {
		FR_IDLE = 2'b01,
		FR_SHIFT = 2'b10
	} frame_state_e;
endpackage

//--- rtl/tx_ctrl_regs.sv
// serial control register bank and power/path control decode of the transmitter
// Operation
// [R1] operating bit 15 picks low LO port when 1, high LO port when 0
// [R2] rf_turbo_hold keeps RF turbo current after acquisition, only if RF turbo enabled
// [R3] if_turbo_hold keeps IF turbo current after acquisition, only if IF turbo enabled
// [R4] band mode bits 12:11: FM, cellular, upper PCS, lower PCS amplifier outputs
// [R5] bit 10 picks high IF pair; controller clears it in FM mode
// [R6] bit 9 picks high-band IF oscillator, else low-band
// [R7] bits 8:6 give IF gain step, about 2dB per count
// [R8] bit 5 picks upper sideband when 1, lower when 0
// [R9] bit 4 powers the buffered IF LO output
// [R10] bit 3 picks quadrature modulation, else direct oscillator modulation
// [R11] standby bit low powers down all but registers and serial interface
// [R12] tx hold bit low stops modulator and upconverter, like transmit-gate pin
// [R13] soft power-off low powers down all but serial port, restores defaults
// [R14] setup bits 15 and 14 low shut IF and RF synthesizers
// [R15] controller writes zero to reserved setup bit 13
// [R16] setup bit 11 inserts divide-by-two on IF LO output
// [R17] bits 9:8 set IF pump current code 175 to 465 uA
// [R18] bits 7:6 set RF pump current in four ascending steps
// [R19] setup bits 5 and 4 set IF and RF detector polarity
// [R20] setup bits 3 and 2 enable IF and RF turbo charging
// [R21] bits 1:0 select settled output: IF, RF or both
// [R22] rx listen pin low stops IF chain; hard power-off stops all
// [R23] 24-bit frame MSB first, address last, latched when chip select rises
// [R24] operating word at address 4, setup word at address 5
// [R25] turbo ends after second lead/lag reversal or acquisition unless held
// [R26] unmatched address changes nothing; no readback path
`timescale 1ns/1ps
`default_nettype none
module tx_ctrl_regs
	import tx_ctrl_pkg::*;
(
	input wire logic clk_in,
	input wire logic rst_n_in,
	// serial link, own clock domain
	input wire logic sclk_in,
	input wire logic sdata_in,
	input wire logic cs_n_in,
	// override pins and analog status, asynchronous
	input wire logic hard_power_off_pin_n_in,
	input wire logic rx_listen_pin_n_in,
	input wire logic tx_gate_pin_n_in,
	input wire logic if_lock_in,
	input wire logic rf_lock_in,
	input wire logic if_phase_lead_in,
	input wire logic rf_phase_lead_in,
	// decoded controls
	output logic lo_port_select_out,
	output logic cell_pa_out,
	output logic pcs_hi_pa_out,
	output logic pcs_lo_pa_out,
	output logic fm_mode_out,
	output logic if_port_high_sel_out,
	output logic if_osc_high_out,
	output logic if_osc_low_out,
	output logic [2:0] if_gain_step_out,
	output logic upper_sideband_sel_out,
	output logic if_lo_tap_on_out,
	output logic lo_tap_halve_out,
	output logic modulation_kind_out,
	output logic modulator_on_out,
	output logic upconverter_on_out,
	output logic if_synth_on_out,
	output logic rf_synth_on_out,
	output logic baseband_level_sel_out,
	output logic ext_osc_input_sel_out,
	output logic [1:0] if_pump_current_out,
	output logic [1:0] rf_pump_current_out,
	output logic if_detector_polarity_out,
	output logic rf_detector_polarity_out,
	output logic if_turbo_on_out,
	output logic rf_turbo_on_out,
	output logic pll_settled_out,
	output logic [7:0] test_mode_word_out
);
	// link domain: shift register runs on sclk while chip select is low
	logic [FRAME_BITS-1:0] shift_r;
	// no reset here: the link has none of its own, and a full frame overwrites
	// every stale start-up bit before chip select rises and commits it
	// the core never sees sclk; a frame crosses as a word that stays still while
	// chip select is high, copied through two flops in the core domain
	always_ff @(posedge sclk_in) begin
		if (!cs_n_in) begin
			shift_r <= {shift_r[FRAME_BITS-2:0], sdata_in}; // [R23]
		end
	end

	// synchronisers into clk_in
	logic [2:0] cs_sync_r;
	logic [FRAME_BITS-1:0] frame_meta_r;
	logic [FRAME_BITS-1:0] frame_r;
	logic [1:0] hpo_sync_r, rxl_sync_r, txg_sync_r, ifl_sync_r, rfl_sync_r;
	logic [2:0] ifp_sync_r, rfp_sync_r;

	// phase detectors get a third stage so a reversal is seen between settled samples
	pin_sync #(.STAGES(3)) u_cs_sync (
		.clk_in(clk_in),
		.d_in(cs_n_in),
		.q_out(cs_sync_r)
	);

	pin_sync #(.STAGES(2)) u_hpo_sync (
		.clk_in(clk_in),
		.d_in(hard_power_off_pin_n_in),
		.q_out(hpo_sync_r)
	);

	pin_sync #(.STAGES(2)) u_rxl_sync (
		.clk_in(clk_in),
		.d_in(rx_listen_pin_n_in),
		.q_out(rxl_sync_r)
	);

	pin_sync #(.STAGES(2)) u_txg_sync (
		.clk_in(clk_in),
		.d_in(tx_gate_pin_n_in),
		.q_out(txg_sync_r)
	);

	pin_sync #(.STAGES(2)) u_ifl_sync (
		.clk_in(clk_in),
		.d_in(if_lock_in),
		.q_out(ifl_sync_r)
	);

	pin_sync #(.STAGES(2)) u_rfl_sync (
		.clk_in(clk_in),
		.d_in(rf_lock_in),
		.q_out(rfl_sync_r)
	);

	pin_sync #(.STAGES(3)) u_ifp_sync (
		.clk_in(clk_in),
		.d_in(if_phase_lead_in),
		.q_out(ifp_sync_r)
	);

	pin_sync #(.STAGES(3)) u_rfp_sync (
		.clk_in(clk_in),
		.d_in(rf_phase_lead_in),
		.q_out(rfp_sync_r)
	);

	always_ff @(posedge clk_in) begin
		frame_meta_r <= shift_r;
		frame_r <= frame_meta_r;
	end

	// the shift register is stable while chip select is high, so a two-stage
	// copy is settled by the time the synchronised rising edge is seen
	wire cs_rise = cs_sync_r[1] & ~cs_sync_r[2];
	wire [3:0] frame_addr = frame_r[ADDR_BITS-1:0];
	wire [15:0] frame_data = frame_r[ADDR_BITS+15:ADDR_BITS];
	wire hard_off = ~hpo_sync_r[1];
	wire wr_op = cs_rise & (frame_addr == ADDR_OPERATING_CONTROL_WORD); // [R24]
	wire wr_cf = cs_rise & (frame_addr == ADDR_SETUP); // [R24]
	wire wr_test = cs_rise & (frame_addr == ADDR_TEST);

	frame_state_e fr_state_r;
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			fr_state_r <= FR_IDLE;
		end else begin
			case (fr_state_r)
				FR_IDLE: fr_state_r <= cs_sync_r[1] ? FR_IDLE : FR_SHIFT;
				FR_SHIFT: fr_state_r <= cs_sync_r[1] ? FR_IDLE : FR_SHIFT;
				default: fr_state_r <= FR_IDLE;
			endcase
		end
	end

	// a rise with no low period before it, as at start-up, commits nothing
	wire commit = (fr_state_r == FR_SHIFT) & cs_rise;

	// registers; hard power-off and soft power-off both restore defaults
	// a commit in the same cycle wins over soft power-off but not over hard; the soft defaults follow one cycle later
	logic [15:0] op_r;
	logic [15:0] cf_r;
	// the test word is only stored and shown; nothing in this block obeys it
	logic [7:0] test_r;
	wire soft_off = ~op_r[OP_SOFTOFF];
	always_ff @(posedge clk_in) begin
		if (!rst_n_in || hard_off) begin // [R22]
			op_r <= OPERATING_CONTROL_WORD_RESET;
			cf_r <= SETUP_RESET;
			test_r <= TEST_RESET;
		end else if (commit && wr_op) begin
			op_r <= frame_data; // [R23]
		end else if (commit && wr_cf) begin
			cf_r <= frame_data; // [R15]
		end else if (commit && wr_test) begin
			test_r <= frame_data[7:0];
		end else if (soft_off) begin
			// soft power-off restores defaults, which also clears itself
			op_r <= OPERATING_CONTROL_WORD_RESET; // [R13]
			cf_r <= SETUP_RESET; // [R13]
			test_r <= TEST_RESET;
		end
		// any other address leaves all registers alone [R26]
	end

	// power gating terms
	wire core_on = ~hard_off & ~soft_off & op_r[OP_STANDBY_KEEP_REGS]; // [R11] [R13]
	wire if_chain_on = core_on & rxl_sync_r[1]; // [R22]
	wire tx_on = if_chain_on & op_r[OP_TXHOLD] & txg_sync_r[1]; // [R12]
	wire if_synth_en = if_chain_on & cf_r[CF_IF_SYNTH]; // [R14]
	wire rf_synth_en = core_on & cf_r[CF_RF_SYNTH]; // [R14]
	wire [1:0] band = op_r[OP_MODE_HI:OP_MODE_LO];
	// amplifier, port and oscillator selection, registered once below
	wire cell_sel = tx_on & (band == BAND_CELL); // [R4]
	wire pcs_hi_sel = tx_on & (band == BAND_PCS_HI); // [R4]
	wire pcs_lo_port_select = tx_on & (band == BAND_PCS_LO); // [R4]
	wire fm_sel = (band == BAND_FM); // [R4]
	// FM mode forces the low pair in case the controller forgot
	wire if_high_pair = op_r[OP_IF_BAND] & (band != BAND_FM); // [R5]
	wire osc_high_on = if_chain_on & op_r[OP_OSC_HI]; // [R6]
	wire osc_low_on = if_chain_on & ~op_r[OP_OSC_HI]; // [R6]
	wire tap_on = if_chain_on & op_r[OP_TAP_ON]; // [R9]
	wire mod_on = tx_on & op_r[OP_MODKIND]; // [R10] [R12]

	// turbo charge for each loop; outputs registered below
	logic if_turbo, rf_turbo;
	turbo_ctrl u_if_turbo (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.synth_en_in(if_synth_en),
		.locked_in(ifl_sync_r[1]),
		.lead_in(ifp_sync_r[1]),
		.lead_prev_in(ifp_sync_r[2]),
		.fast_en_in(cf_r[CF_IF_FAST]), // [R20]
		.hold_in(op_r[OP_IF_HOLD]), // [R3]
		.turbo_out(if_turbo)
	);

	turbo_ctrl u_rf_turbo (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.synth_en_in(rf_synth_en),
		.locked_in(rfl_sync_r[1]),
		.lead_in(rfp_sync_r[1]),
		.lead_prev_in(rfp_sync_r[2]),
		.fast_en_in(cf_r[CF_RF_FAST]), // [R20]
		.hold_in(op_r[OP_RF_HOLD]), // [R2]
		.turbo_out(rf_turbo)
	);

	logic settled;
	always_comb begin
		case (cf_r[CF_SETTLE_HI:CF_SETTLE_LO])
			SETTLE_IF: settled = ifl_sync_r[1]; // [R21]
			SETTLE_RF: settled = rfl_sync_r[1]; // [R21]
			SETTLE_BOTH: settled = ifl_sync_r[1] & rfl_sync_r[1]; // [R21]
			default: settled = 1'b0;
		endcase
	end

	// registered outputs
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			lo_port_select_out <= 1'b0;
			cell_pa_out <= 1'b0;
			pcs_hi_pa_out <= 1'b0;
			pcs_lo_pa_out <= 1'b0;
			fm_mode_out <= 1'b0;
			if_port_high_sel_out <= 1'b0;
			if_osc_high_out <= 1'b0;
			if_osc_low_out <= 1'b0;
			if_gain_step_out <= 3'h0;
			upper_sideband_sel_out <= 1'b0;
			if_lo_tap_on_out <= 1'b0;
			lo_tap_halve_out <= 1'b0;
			modulation_kind_out <= 1'b0;
			modulator_on_out <= 1'b0;
			upconverter_on_out <= 1'b0;
			if_synth_on_out <= 1'b0;
			rf_synth_on_out <= 1'b0;
			baseband_level_sel_out <= 1'b0;
			ext_osc_input_sel_out <= 1'b0;
			if_pump_current_out <= 2'h0;
			rf_pump_current_out <= 2'h0;
			if_detector_polarity_out <= 1'b0;
			rf_detector_polarity_out <= 1'b0;
			if_turbo_on_out <= 1'b0;
			rf_turbo_on_out <= 1'b0;
			pll_settled_out <= 1'b0;
			test_mode_word_out <= 8'h00;
		end else begin
			lo_port_select_out <= op_r[OP_LO_PORT_SELECT]; // [R1]
			cell_pa_out <= cell_sel; // [R4]
			pcs_hi_pa_out <= pcs_hi_sel; // [R4]
			pcs_lo_pa_out <= pcs_lo_port_select; // [R4]
			fm_mode_out <= fm_sel; // [R4]
			if_port_high_sel_out <= if_high_pair; // [R5]
			if_osc_high_out <= osc_high_on; // [R6]
			if_osc_low_out <= osc_low_on; // [R6]
			if_gain_step_out <= op_r[OP_GAIN_HI:OP_GAIN_LO]; // [R7]
			upper_sideband_sel_out <= op_r[OP_SIDEBAND]; // [R8]
			if_lo_tap_on_out <= tap_on; // [R9]
			lo_tap_halve_out <= cf_r[CF_HALVE]; // [R16]
			modulation_kind_out <= op_r[OP_MODKIND]; // [R10]
			modulator_on_out <= mod_on; // [R10] [R12]
			upconverter_on_out <= tx_on; // [R12]
			if_synth_on_out <= if_synth_en; // [R14]
			rf_synth_on_out <= rf_synth_en; // [R14]
			baseband_level_sel_out <= cf_r[CF_LEVEL];
			ext_osc_input_sel_out <= cf_r[CF_EXTOSC];
			if_pump_current_out <= cf_r[CF_ICP_HI:CF_ICP_LO]; // [R17]
			rf_pump_current_out <= cf_r[CF_RCP_HI:CF_RCP_LO]; // [R18]
			if_detector_polarity_out <= cf_r[CF_IF_POL]; // [R19]
			rf_detector_polarity_out <= cf_r[CF_RF_POL]; // [R19]
			if_turbo_on_out <= if_turbo;
			rf_turbo_on_out <= rf_turbo;
			pll_settled_out <= settled;
			test_mode_word_out <= test_r;
		end
	end
endmodule // tx_ctrl_regs

// flip-flop chain that brings one level from another clock domain
module pin_sync #(
	parameter int STAGES = 2
) (
	input wire logic clk_in,
	input wire logic d_in,
	output logic [STAGES-1:0] q_out
);
	// stage 0 may be metastable; only later stages may feed logic
	// single levels only: a word passed bit by bit here could arrive torn
	always_ff @(posedge clk_in) begin
		q_out <= {q_out[STAGES-2:0], d_in};
	end
endmodule // pin_sync

// turbo charge control for one synthesizer loop
module turbo_ctrl
	import tx_ctrl_pkg::*;
(
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic synth_en_in,
	input wire logic locked_in,
	// settled phase-detector level and the sample before it
	input wire logic lead_in,
	input wire logic lead_prev_in,
	// programmed enables from the setup and operating words
	input wire logic fast_en_in,
	input wire logic hold_in,
	output logic turbo_out
);
	logic [1:0] rev_r;
	logic [1:0] rev_nxt;

	// a lead/lag reversal is a change between two settled samples of the detector
	wire flip = lead_in ^ lead_prev_in;
	wire rev_done = (rev_r == REVERSALS_END);
	// the count restarts only when the loop is switched off, so a loop that has
	// already seen two reversals stays at programmed current if lock drops later
	assign rev_nxt = !synth_en_in ? 2'd0 :
		(flip && !rev_done) ? rev_r + 2'd1 : rev_r; // [R25]

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			rev_r <= 2'd0;
		end else begin
			rev_r <= rev_nxt;
		end
	end
	// acquiring while switched off or unlocked, and before the second reversal
	wire acquiring = (~synth_en_in | ~locked_in) & ~rev_done; // [R25]
	assign turbo_out = synth_en_in & fast_en_in & (acquiring | hold_in); // [R2] [R3] [R20]
endmodule // turbo_ctrl
`default_nettype wire

//--- test/serial_host.sv
// model of the baseband controller writing frames on the 3-wire link
`timescale 1ns/1ps
`default_nettype none
module serial_host (
	output var logic sclk_out,
	output var logic sdata_out,
	output var logic cs_n_out
);
	initial begin
		sclk_out = 1'b0;
		sdata_out = 1'b0;
		cs_n_out = 1'b1;
	end
	// link clock runs only inside a frame, 125 ns period, no phase tie to the core clock
	task automatic send(input logic [23:0] frame);
		int i;
		#3.7;
		cs_n_out = 1'b0;
		for (i = 23; i >= 0; i--) begin
			sdata_out = frame[i];
			#62.5 sclk_out = 1'b1;
			#62.5 sclk_out = 1'b0;
		end
		#40 cs_n_out = 1'b1;
		// released data line shows the inverse so no stale bit looks valid
		sdata_out = ~sdata_out;
	endtask
endmodule // serial_host
`default_nettype wire

//--- test/tx_ctrl_regs_sva.sv
// assertion checker for the transmitter control register bank
`timescale 1ns/1ps
`default_nettype none
module tx_ctrl_regs_chk (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic hard_power_off_pin_n_in,
	input wire logic rx_listen_pin_n_in,
	input wire logic tx_gate_pin_n_in,
	input wire logic if_lock_in,
	input wire logic rf_lock_in,
	input wire logic cell_pa_out,
	input wire logic pcs_hi_pa_out,
	input wire logic pcs_lo_pa_out,
	input wire logic fm_mode_out,
	input wire logic if_port_high_sel_out,
	input wire logic if_osc_high_out,
	input wire logic if_osc_low_out,
	input wire logic if_lo_tap_on_out,
	input wire logic modulator_on_out,
	input wire logic upconverter_on_out,
	input wire logic if_synth_on_out,
	input wire logic rf_synth_on_out,
	input wire logic pll_settled_out,
	input wire logic [7:0] test_mode_word_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	AST_BAND: assert property (
		$onehot0({fm_mode_out, cell_pa_out, pcs_hi_pa_out, pcs_lo_pa_out})) else $error("band");
	AST_PA_TX: assert property (
		(cell_pa_out | pcs_hi_pa_out | pcs_lo_pa_out) |-> upconverter_on_out) else $error("pa");
	AST_FM_IF: assert property (
		fm_mode_out |-> !if_port_high_sel_out) else $error("fm if port");
	AST_OSC: assert property (
		!(if_osc_high_out && if_osc_low_out)) else $error("osc");
	AST_TAP: assert property (
		if_lo_tap_on_out |-> (if_osc_high_out || if_osc_low_out)) else $error("tap");
	AST_MOD: assert property (
		modulator_on_out |-> upconverter_on_out) else $error("mod");
	AST_GATE: assert property (
		!tx_gate_pin_n_in [*4] |=> !upconverter_on_out && !modulator_on_out) else $error("gate");
	AST_LISTEN: assert property (
		!rx_listen_pin_n_in [*4] |=> !(if_lo_tap_on_out | if_synth_on_out | if_osc_low_out))
		else $error("listen");
	AST_HARD: assert property (
		!hard_power_off_pin_n_in [*4] |=> !rf_synth_on_out && test_mode_word_out == 8'h00)
		else $error("hard off");
	AST_LOCK: assert property (
		(!if_lock_in && !rf_lock_in) [*4] |=> !pll_settled_out) else $error("settled");
	cover property (pcs_hi_pa_out);
	cover property (fm_mode_out);
	cover property (pll_settled_out);
endmodule // tx_ctrl_regs_chk
bind tx_ctrl_regs tx_ctrl_regs_chk u_chk (.clk_in, .rst_n_in, .hard_power_off_pin_n_in,
	.rx_listen_pin_n_in, .tx_gate_pin_n_in, .if_lock_in, .rf_lock_in, .cell_pa_out,
	.pcs_hi_pa_out, .pcs_lo_pa_out, .fm_mode_out, .if_port_high_sel_out, .if_osc_high_out,
	.if_osc_low_out, .if_lo_tap_on_out, .modulator_on_out, .upconverter_on_out,
	.if_synth_on_out, .rf_synth_on_out, .pll_settled_out, .test_mode_word_out);
`default_nettype wire

//--- test/tb_tx_ctrl_regs.sv
// self-checking bench for the transmitter control register bank
`timescale 1ns/1ps
`default_nettype none
module tb_tx_ctrl_regs
	import tx_ctrl_pkg::*;
;
	logic clk_in = 0, rst_n_in = 0, hp_n = 1, rx_n = 1, tg_n = 1;
	logic if_lk = 0, rf_lk = 0, if_ld = 0, rf_ld = 0;
	logic [15:0] op_m = OPERATING_CONTROL_WORD_RESET, cf_m = SETUP_RESET;
	logic [7:0] tm_m = TEST_RESET;
	wire logic [35:0] obs;
	wire logic [1:0] turbo_obs;
	logic [1:0] turbo_q[$];
	int if_rev = 0, rf_rev = 0;
	logic [35:0] exp_q[$];
	wire logic sclk, sdata, cs_n;
	int errors = 0, samples_checked = 0, cycles = 0, seed = 84149;
	event chk_ev;
	always #5 clk_in = ~clk_in;
	serial_host u_host (.sclk_out(sclk), .sdata_out(sdata), .cs_n_out(cs_n));
	tx_ctrl_regs u_dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .sclk_in(sclk), .sdata_in(sdata),
		.cs_n_in(cs_n), .hard_power_off_pin_n_in(hp_n), .rx_listen_pin_n_in(rx_n),
		.tx_gate_pin_n_in(tg_n), .if_lock_in(if_lk), .rf_lock_in(rf_lk),
		.if_phase_lead_in(if_ld), .rf_phase_lead_in(rf_ld), .lo_port_select_out(obs[35]),
		.cell_pa_out(obs[34]), .pcs_hi_pa_out(obs[33]), .pcs_lo_pa_out(obs[32]),
		.fm_mode_out(obs[31]), .if_port_high_sel_out(obs[30]), .if_osc_high_out(obs[29]),
		.if_osc_low_out(obs[28]), .if_gain_step_out(obs[27:25]), .upper_sideband_sel_out(obs[24]),
		.if_lo_tap_on_out(obs[23]), .lo_tap_halve_out(obs[22]), .modulation_kind_out(obs[21]),
		.modulator_on_out(obs[20]), .upconverter_on_out(obs[19]), .if_synth_on_out(obs[18]),
		.rf_synth_on_out(obs[17]), .baseband_level_sel_out(obs[16]),
		.ext_osc_input_sel_out(obs[15]), .if_pump_current_out(obs[14:13]),
		.rf_pump_current_out(obs[12:11]), .if_detector_polarity_out(obs[10]),
		.rf_detector_polarity_out(obs[9]), .if_turbo_on_out(turbo_obs[1]),
		.rf_turbo_on_out(turbo_obs[0]),
		.pll_settled_out(obs[8]), .test_mode_word_out(obs[7:0]));
	function automatic logic [35:0] expect_obs();
		logic core, ifon, tx, s;
		logic [1:0] b;
		core = hp_n & op_m[OP_SOFTOFF] & op_m[OP_STANDBY_KEEP_REGS];
		ifon = core & rx_n;
		tx = ifon & op_m[OP_TXHOLD] & tg_n;
		b = op_m[OP_MODE_HI:OP_MODE_LO];
		s = (cf_m[1:0] != 2'b00) & (!cf_m[0] | if_lk) & (!cf_m[1] | rf_lk);
		return {op_m[15], b == BAND_CELL & tx, b == BAND_PCS_HI & tx, b == BAND_PCS_LO & tx,
			b == BAND_FM, op_m[10] & b != BAND_FM, op_m[9] & ifon, !op_m[9] & ifon, op_m[8:6],
			op_m[5], op_m[4] & ifon, cf_m[11], op_m[3], tx & op_m[3], tx, cf_m[15] & ifon,
			cf_m[14] & core, cf_m[12], cf_m[10], cf_m[9:8], cf_m[7:6], cf_m[5], cf_m[4], s, tm_m};
	endfunction
	task automatic compare_obs(input logic [35:0] e, input logic [35:0] a);
		samples_checked++;
		if (a !== e) begin
			errors++;
			$display("mismatch outputs expected %h seen %h", e, a);
		end
	endtask
	task automatic compare_turbo(input logic [1:0] e, input logic [1:0] a);
		samples_checked++;
		if (a !== e) begin
			errors++;
			$display("mismatch turbo expected %b seen %b", e, a);
		end
	endtask
	task automatic report_and_stop();
		$display("errors=%0d samples_checked=%0d", errors, samples_checked);
		if (errors == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	always @(chk_ev) begin
		#1;
		compare_obs(exp_q.pop_front(), obs);
		compare_turbo(turbo_q.pop_front(), turbo_obs);
	end
	always @(posedge clk_in) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			errors++;
			report_and_stop();
		end
	end
	initial begin
		logic [3:0] a;
		logic [15:0] d;
		logic [1:0] ld_old;
		logic ifen, rfen;
		repeat (4) @(posedge clk_in);
		rst_n_in <= 1'b1;
		repeat (6) @(posedge clk_in);
		for (int i = 0; i < 32; i++) begin
			// unmapped slot first in each group of four, so defaults and ignores are seen
			a = (i % 4 == 0) ? (i[2] ? 4'hf : 4'h6) : (i % 4 == 1) ? ADDR_OPERATING_CONTROL_WORD :
				(i % 4 == 2) ? ADDR_SETUP : ADDR_TEST;
			d = 16'($random(seed));
			if (a == ADDR_OPERATING_CONTROL_WORD) begin
				d[OP_MODE_HI:OP_MODE_LO] = i[3:2];
				d[OP_SOFTOFF] = (i != 17);
				d[OP_STANDBY_KEEP_REGS] = (i != 25);
				if (i[3:2] == 2'b00)
					d[OP_IF_BAND] = 1'b0;
			end
			if (a == ADDR_SETUP) begin
				d[13] = 1'b0;
				if (d[1:0] == 2'b00)
					d[CF_SETTLE_LO] = 1'b1;
			end
			@(posedge clk_in);
			ld_old = {if_ld, rf_ld};
			hp_n <= (i % 8 != 6);
			rx_n <= 1'($random(seed));
			tg_n <= 1'($random(seed));
			{if_lk, rf_lk, if_ld, rf_ld} <= 4'($random(seed));
			u_host.send({4'h0, d, a});
			// lead/lag flips are counted early, under the old words and the new pins
			ifen = hp_n & rx_n & op_m[OP_SOFTOFF] & op_m[OP_STANDBY_KEEP_REGS] & cf_m[CF_IF_SYNTH];
			rfen = hp_n & op_m[OP_SOFTOFF] & op_m[OP_STANDBY_KEEP_REGS] & cf_m[CF_RF_SYNTH];
			if_rev = !ifen ? 0 : (ld_old[1] != if_ld && if_rev < 2) ? if_rev + 1 : if_rev;
			rf_rev = !rfen ? 0 : (ld_old[0] != rf_ld && rf_rev < 2) ? rf_rev + 1 : rf_rev;
			if (hp_n) begin
				if (a == ADDR_OPERATING_CONTROL_WORD)
					op_m = d;
				if (a == ADDR_SETUP)
					cf_m = d;
				if (a == ADDR_TEST)
					tm_m = d[7:0];
			end
			// the committed word stands for a cycle, so a loop it switches off restarts
			if (!(hp_n & rx_n & op_m[OP_SOFTOFF] & op_m[OP_STANDBY_KEEP_REGS] & cf_m[CF_IF_SYNTH]))
				if_rev = 0;
			if (!(hp_n & op_m[OP_SOFTOFF] & op_m[OP_STANDBY_KEEP_REGS] & cf_m[CF_RF_SYNTH]))
				rf_rev = 0;
			if (!hp_n || !op_m[OP_SOFTOFF]) begin
				op_m = OPERATING_CONTROL_WORD_RESET;
				cf_m = SETUP_RESET;
				tm_m = TEST_RESET;
			end
			repeat (12) @(posedge clk_in);
			exp_q.push_back(expect_obs());
			ifen = hp_n & rx_n & op_m[OP_SOFTOFF] & op_m[OP_STANDBY_KEEP_REGS] & cf_m[CF_IF_SYNTH];
			rfen = hp_n & op_m[OP_SOFTOFF] & op_m[OP_STANDBY_KEEP_REGS] & cf_m[CF_RF_SYNTH];
			turbo_q.push_back({ifen & cf_m[CF_IF_FAST] & (op_m[OP_IF_HOLD] | (!if_lk & if_rev < 2)),
				rfen & cf_m[CF_RF_FAST] & (op_m[OP_RF_HOLD] | (!rf_lk & rf_rev < 2))});
			-> chk_ev;
		end
		repeat (4) @(posedge clk_in);
		report_and_stop();
	end
endmodule // tb_tx_ctrl_regs
`default_nettype wire
